// ===== pkg/pgs_defines.svh
// Offsets, field positions and reset values of the gigabit status block
`ifndef PGS_DEFINES_SVH
`define PGS_DEFINES_SVH
// Register word indices; byte address is four times the index
`define PGS_IDX_GCTL 3'h0
`define PGS_IDX_GSTAT 3'h1
`define PGS_IDX_MSET 3'h2
`define PGS_IDX_MDATA 3'h3
`define PGS_IDX_ISTAT 3'h4
`define PGS_IDX_IMASK 3'h5
// Control and status field positions
`define PGS_B_ADV_HD 8
`define PGS_B_FAULT 15
`define PGS_B_MASTER 14
`define PGS_B_LRX 13
`define PGS_B_RRX 12
`define PGS_B_LPFD 11
`define PGS_B_LPHD 10
`define PGS_CNT_MAX 8'hff
`define PGS_CNT_RST 8'h00
// Setup register fields and modes
`define PGS_MODE_HI 15
`define PGS_MODE_LO 14
`define PGS_DEV_HI 4
`define PGS_MODE_REG 2'h0
`define PGS_MODE_DATA 2'h1
`define PGS_MODE_INC_RW 2'h2
`define PGS_MODE_INC_W 2'h3
`define PGS_DEV_RST 5'h00
`define PGS_ADDR_RST 16'h0000
// Interrupt bits
`define PGS_IRQ_FAULT 0
`define PGS_IRQ_IDLE 1
`define PGS_IRQ_RST 2'h0
`endif

// ===== pkg/pgs_pkg.sv
// Types shared by the gigabit status register block
`include "pgs_defines.svh"
package pgs_pkg;
  typedef enum logic [1:0] {
    PGS_BUS_IDLE = 2'h1,
    PGS_BUS_ACK = 2'h2
  } pgs_bus_t;

  typedef struct packed {
    pgs_bus_t bus;
    logic adv_hd;
    logic fault;
    logic [7:0] idle_cnt;
    logic [1:0] mode;
    logic [4:0] dev;
    logic [15:0] reg_addr;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic mmd_wr;
    logic mmd_rd;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [31:0] rdata;
  } pgs_state_t;
endpackage : pgs_pkg

// ===== logic/pgs_regs.sv
// Gigabit status, advertisement and indirect-access setup registers on Avalon-MM
// Behaviour
// - Control bit 8 advertises gigabit half duplex when set; resets cleared.
// - Status bit 15 latches high on master-slave fault; read-only, resets zero.
// - Status bit 14 shows resolved role: one master, zero slave.
// - Status bit 13 shows local receiver health, read-only.
// - Status bit 12 shows remote receiver health, read-only.
// - Bits 11 and 10 show partner gigabit full and half duplex ability.
// - Bits 7:0 hold 8-bit idle error count, counted during idles with Send_N.
// - Counter advances once per symbol period flagged as error.
// - Setup bits 15:14 pick register, data, inc on all, inc on writes.
// - Mode field steers use of the data register; resets to zero.
// - Setup bits 4:0 hold target device address, read-write, reset zero.
// - Data register holds register address in mode zero, else data.
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module pgs_regs (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic IRQ,
  input wire logic MS_FAULT,
  input wire logic MS_MASTER,
  input wire logic LOC_RX_OK,
  input wire logic REM_RX_OK,
  input wire logic LP_1000_FD,
  input wire logic LP_1000_HD,
  input wire logic SYMBOL_EN,
  input wire logic RX_IDLE,
  input wire logic TX_SEND_N,
  input wire logic RX_ERROR,
  output logic ADV_1000_HD,
  output logic [4:0] MMD_DEV_ADDR,
  output logic [15:0] MMD_REG_ADDR,
  input wire logic [15:0] MMD_RD_DATA,
  output logic MMD_RD,
  output logic MMD_WR,
  output logic [15:0] MMD_WR_ADDR,
  output logic [15:0] MMD_WR_DATA
);
  import pgs_pkg::*;

  pgs_state_t st_reg;
  pgs_state_t st_next;
  logic rd_take;
  logic wr_take;
  logic stat_clr;
  logic err_ev;

  // Word index match, low address bits ignored
  function automatic logic pgs_hit(input logic [4:0] a, input logic [2:0] idx);
    return a[4:2] == idx;
  endfunction : pgs_hit

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] pgs_merge(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : pgs_merge

  // Status word view, used by the read path only
  function automatic logic [15:0] pgs_status(input pgs_state_t s, input logic m,
                                             input logic l, input logic r,
                                             input logic fd, input logic hd);
    logic [15:0] v;
    v = 16'h0000;
    v[`PGS_B_FAULT] = s.fault;
    v[`PGS_B_MASTER] = m;
    v[`PGS_B_LRX] = l;
    v[`PGS_B_RRX] = r;
    v[`PGS_B_LPFD] = fd;
    v[`PGS_B_LPHD] = hd;
    v[7:0] = s.idle_cnt;
    return v;
  endfunction : pgs_status

  // Reads act on the first cycle, writes on the acknowledged one
  assign rd_take = AVS_READ && (st_reg.bus == PGS_BUS_IDLE);
  assign wr_take = AVS_WRITE && (st_reg.bus == PGS_BUS_ACK);
  assign stat_clr = rd_take && pgs_hit(AVS_ADDRESS, `PGS_IDX_GSTAT);
  assign err_ev = SYMBOL_EN && RX_IDLE && TX_SEND_N && RX_ERROR;

  // Next-state logic for bus, status and setup
  always_comb begin
    logic [15:0] wm;
    logic [7:0] cnt;
    wm = 16'h0000;
    cnt = 8'h00;
    st_next = st_reg;
    st_next.mmd_wr = 1'b0;
    st_next.mmd_rd = 1'b0;
    // One wait state for every request
    case (st_reg.bus)
      PGS_BUS_IDLE: begin
        if (AVS_READ || AVS_WRITE) begin
          st_next.bus = PGS_BUS_ACK;
        end
      end
      PGS_BUS_ACK: begin
        st_next.bus = PGS_BUS_IDLE;
      end
      default: begin
        st_next.bus = PGS_BUS_IDLE;
      end
    endcase
    // Fault latches; a new fault beats the read clear
    st_next.fault = MS_FAULT || (st_reg.fault && !stat_clr);
    // Count restarts on read, then an error in the same cycle still counts
    cnt = stat_clr ? `PGS_CNT_RST : st_reg.idle_cnt;
    if (err_ev && (cnt != `PGS_CNT_MAX)) begin
      cnt = cnt + 8'h01;
    end
    st_next.idle_cnt = cnt;
    // Read data captured at the first edge so it stands when waitrequest drops
    if (rd_take) begin
      st_next.rdata = 32'h0000_0000;
      case (AVS_ADDRESS[4:2])
        `PGS_IDX_GCTL: begin
          st_next.rdata[`PGS_B_ADV_HD] = st_reg.adv_hd;
        end
        `PGS_IDX_GSTAT: begin
          st_next.rdata[15:0] = pgs_status(st_reg, MS_MASTER, LOC_RX_OK,
                                           REM_RX_OK, LP_1000_FD,
                                           LP_1000_HD);
        end
        `PGS_IDX_MSET: begin
          st_next.rdata[`PGS_MODE_HI:`PGS_MODE_LO] = st_reg.mode;
          st_next.rdata[`PGS_DEV_HI:0] = st_reg.dev;
        end
        `PGS_IDX_MDATA: begin
          if (st_reg.mode == `PGS_MODE_REG) begin
            st_next.rdata[15:0] = st_reg.reg_addr;
          end else begin
            st_next.rdata[15:0] = MMD_RD_DATA;
            st_next.mmd_rd = 1'b1;
            if (st_reg.mode == `PGS_MODE_INC_RW) begin
              st_next.reg_addr = st_reg.reg_addr + 16'h0001;
            end
          end
        end
        `PGS_IDX_ISTAT: begin
          st_next.rdata[1:0] = st_reg.irq_stat;
        end
        `PGS_IDX_IMASK: begin
          st_next.rdata[1:0] = st_reg.irq_mask;
        end
        default: begin
          st_next.rdata = 32'h0000_0000;
        end
      endcase
    end
    // Writes; unmapped addresses are acknowledged and dropped
    if (wr_take) begin
      case (AVS_ADDRESS[4:2])
        `PGS_IDX_GCTL: begin
          wm = pgs_merge({7'h00, st_reg.adv_hd, 8'h00}, AVS_WRITEDATA, AVS_BYTEENABLE);
          st_next.adv_hd = wm[`PGS_B_ADV_HD];
        end
        `PGS_IDX_MSET: begin
          wm = pgs_merge({st_reg.mode, 9'h000, st_reg.dev}, AVS_WRITEDATA, AVS_BYTEENABLE);
          st_next.mode = wm[`PGS_MODE_HI:`PGS_MODE_LO];
          st_next.dev = wm[`PGS_DEV_HI:0];
        end
        `PGS_IDX_MDATA: begin
          if (st_reg.mode == `PGS_MODE_REG) begin
            st_next.reg_addr = pgs_merge(st_reg.reg_addr, AVS_WRITEDATA,
                                         AVS_BYTEENABLE);
          end else begin
            st_next.wr_data = pgs_merge(MMD_RD_DATA, AVS_WRITEDATA, AVS_BYTEENABLE);
            st_next.wr_addr = st_reg.reg_addr;
            st_next.mmd_wr = 1'b1;
            if (st_reg.mode != `PGS_MODE_DATA) begin
              st_next.reg_addr = st_reg.reg_addr + 16'h0001;
            end
          end
        end
        `PGS_IDX_ISTAT: begin
          st_next.irq_stat = st_reg.irq_stat & ~AVS_WRITEDATA[1:0];
        end
        `PGS_IDX_IMASK: begin
          st_next.irq_mask = AVS_WRITEDATA[1:0];
        end
        default: begin
          st_next.irq_mask = st_reg.irq_mask;
        end
      endcase
    end
    // Events set after the clear so a same-cycle event is kept
    if (MS_FAULT) begin
      st_next.irq_stat[`PGS_IRQ_FAULT] = 1'b1;
    end
    if (err_ev) begin
      st_next.irq_stat[`PGS_IRQ_IDLE] = 1'b1;
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      st_reg <= '0;
      st_reg.bus <= PGS_BUS_IDLE;
      st_reg.adv_hd <= 1'b0;
      st_reg.fault <= 1'b0;
      st_reg.idle_cnt <= `PGS_CNT_RST;
      st_reg.mode <= `PGS_MODE_REG;
      st_reg.dev <= `PGS_DEV_RST;
      st_reg.reg_addr <= `PGS_ADDR_RST;
      st_reg.irq_stat <= `PGS_IRQ_RST;
      st_reg.irq_mask <= `PGS_IRQ_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs; waitrequest is combinational, everything else from flops
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && (st_reg.bus != PGS_BUS_ACK);
  assign AVS_READDATA = st_reg.rdata;
  assign IRQ = |(st_reg.irq_stat & st_reg.irq_mask);
  assign ADV_1000_HD = st_reg.adv_hd;
  assign MMD_DEV_ADDR = st_reg.dev;
  assign MMD_REG_ADDR = st_reg.reg_addr;
  assign MMD_RD = st_reg.mmd_rd;
  assign MMD_WR = st_reg.mmd_wr;
  assign MMD_WR_ADDR = st_reg.wr_addr;
  assign MMD_WR_DATA = st_reg.wr_data;

  // Checks on the behaviour above
  adv_hd_wr_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_take && pgs_hit(AVS_ADDRESS, `PGS_IDX_GCTL) && AVS_BYTEENABLE[1]
    |=> ADV_1000_HD == $past(AVS_WRITEDATA[`PGS_B_ADV_HD]))
    else $error("half duplex advert not written");

  fault_latch_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    MS_FAULT |=> st_reg.fault && st_reg.irq_stat[`PGS_IRQ_FAULT])
    else $error("fault not latched");

  fault_hold_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    st_reg.fault && !stat_clr |=> st_reg.fault)
    else $error("fault dropped without read");

  fault_clear_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    stat_clr && !MS_FAULT |=> !st_reg.fault)
    else $error("fault kept after read");

  status_view_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    stat_clr |=> !AVS_WAITREQUEST && AVS_READDATA[`PGS_B_MASTER:`PGS_B_LPHD] ==
    $past({MS_MASTER, LOC_RX_OK, REM_RX_OK, LP_1000_FD, LP_1000_HD}))
    else $error("status bits not mirrored");

  cnt_step_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    err_ev && !stat_clr && st_reg.idle_cnt != `PGS_CNT_MAX
    |=> st_reg.idle_cnt == 8'($past(st_reg.idle_cnt) + 8'h01))
    else $error("idle count not advanced");

  cnt_idle_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !err_ev && !stat_clr |=> $stable(st_reg.idle_cnt))
    else $error("idle count moved without error");

  idle_irq_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    err_ev |=> st_reg.irq_stat[`PGS_IRQ_IDLE])
    else $error("idle error event not flagged");

  cnt_sat_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    st_reg.idle_cnt == `PGS_CNT_MAX && !stat_clr |=> st_reg.idle_cnt == `PGS_CNT_MAX)
    else $error("idle count wrapped");

  rd_clear_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    stat_clr |=> st_reg.idle_cnt == {7'h00, $past(err_ev)}
    && AVS_READDATA[7:0] == $past(st_reg.idle_cnt))
    else $error("read clear wrong");

  mode_wr_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_take && pgs_hit(AVS_ADDRESS, `PGS_IDX_MSET) && AVS_BYTEENABLE == 4'hf
    |=> st_reg.mode == $past(AVS_WRITEDATA[`PGS_MODE_HI:`PGS_MODE_LO])
    && MMD_DEV_ADDR == $past(AVS_WRITEDATA[`PGS_DEV_HI:0]))
    else $error("setup write lost");

  data_inc_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_take && pgs_hit(AVS_ADDRESS, `PGS_IDX_MDATA) && st_reg.mode[1]
    |=> MMD_WR && MMD_REG_ADDR == 16'(MMD_WR_ADDR + 16'h0001))
    else $error("post increment missing");

  // Data-mode read must fetch the far side and pulse its strobe
  data_rd_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    rd_take && pgs_hit(AVS_ADDRESS, `PGS_IDX_MDATA) && st_reg.mode != `PGS_MODE_REG
    |=> MMD_RD && AVS_READDATA[15:0] == $past(MMD_RD_DATA))
    else $error("data read not fetched");

  rd_inc_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    rd_take && pgs_hit(AVS_ADDRESS, `PGS_IDX_MDATA) && st_reg.mode == `PGS_MODE_INC_RW
    |=> MMD_REG_ADDR == 16'($past(MMD_REG_ADDR) + 16'h0001))
    else $error("read post increment missing");

  // Register mode only moves the address, never strobes a write
  reg_mode_wr_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_take && pgs_hit(AVS_ADDRESS, `PGS_IDX_MDATA) && st_reg.mode == `PGS_MODE_REG
    && AVS_BYTEENABLE == 4'hf |=> MMD_REG_ADDR == $past(AVS_WRITEDATA[15:0]) && !MMD_WR)
    else $error("register address write lost");
endmodule : pgs_regs

// ===== testbench/pgs_mmd_model.sv
// Far-side model of the indirectly reached register space
`timescale 1ns/100ps
module pgs_mmd_model (
  input wire logic REF_CLK,
  input wire logic MMD_WR,
  input wire logic [15:0] MMD_WR_ADDR,
  input wire logic [15:0] MMD_WR_DATA,
  input wire logic [15:0] MMD_REG_ADDR,
  output logic [15:0] MMD_RD_DATA
);
  logic [15:0] mem [256];
  // Known fill so untouched words read back predictably
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = {8'ha5, i[7:0]};
  end
  // Store each write pulse at its own address
  always @(posedge REF_CLK) begin
    if (MMD_WR) mem[MMD_WR_ADDR[7:0]] <= MMD_WR_DATA;
  end
  // Only 256 words kept, so upper address bits alias
  assign MMD_RD_DATA = mem[MMD_REG_ADDR[7:0]];
endmodule : pgs_mmd_model

// ===== testbench/phy_gig_status_mmd_setup_regs_bench.sv
// Register-level bench for the gigabit status and indirect setup block
`timescale 1ns/100ps
module phy_gig_status_mmd_setup_regs_bench;
  logic clk = 1'b0, rst_n = 1'b0, rd_s = 1'b0, wr_s = 1'b0, flt = 1'b0;
  logic [4:0] adr = 5'h00, lv = 5'h00, dev;
  logic [3:0] ph = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, r;
  logic wq, irq, adv, mrd, mwr;
  logic [15:0] raddr, waddr, wdata, mdat;
  int n_errors = 0, n_checks = 0;

  // Free-running 10 MHz clock
  always #50 clk = ~clk;

  pgs_regs pgs_regs_inst (.REF_CLK(clk), .RESETN(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd_s),
    .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wq), .IRQ(irq), .MS_FAULT(flt), .MS_MASTER(lv[4]), .LOC_RX_OK(lv[3]),
    .REM_RX_OK(lv[2]), .LP_1000_FD(lv[1]), .LP_1000_HD(lv[0]), .SYMBOL_EN(ph[3]),
    .RX_IDLE(ph[2]), .TX_SEND_N(ph[1]), .RX_ERROR(ph[0]), .ADV_1000_HD(adv),
    .MMD_DEV_ADDR(dev), .MMD_REG_ADDR(raddr), .MMD_RD_DATA(mdat), .MMD_RD(mrd),
    .MMD_WR(mwr), .MMD_WR_ADDR(waddr), .MMD_WR_DATA(wdata));

  pgs_mmd_model pgs_mmd_model_inst (.REF_CLK(clk), .MMD_WR(mwr), .MMD_WR_ADDR(waddr),
    .MMD_WR_DATA(wdata), .MMD_REG_ADDR(raddr), .MMD_RD_DATA(mdat));

  task complete_run;
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [2:0] i, input logic [15:0] d);
    int n;
    @(posedge clk);
    adr <= {i, 2'h0};
    wdat <= {16'h0, d};
    rd_s <= ~w;
    wr_s <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_errors++;
      complete_run();
    end else begin
      r = rdat;
      rd_s <= 1'b0;
      wr_s <= 1'b0;
    end
  endtask : bus

  task automatic wr(input logic [2:0] i, input logic [15:0] d);
    bus(1'b1, i, d);
  endtask : wr

  task automatic rd(input logic [2:0] i);
    bus(1'b0, i, 16'h0);
  endtask : rd

  // Holds one symbol-side pattern for n cycles, then idles
  task automatic ev(input int n, input logic [3:0] p);
    repeat (n) @(posedge clk) ph <= p;
    @(posedge clk) ph <= 4'h0;
  endtask : ev

  // Lets registered outputs settle before sampling
  task settle;
    repeat (2) @(posedge clk);
  endtask : settle

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(3'h0); chk(r, 32'h0);
    wr(3'h0, 16'h0100); rd(3'h0); chk(r, 32'h100);
    chk(adv, 1'b1);
    rd(3'h2); chk(r, 32'h0);
    // Complementary patterns show each live status bit at both values
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) lv <= k ? 5'h15 : 5'h0a;
      rd(3'h1); chk(r, {16'h0, 1'b0, (k ? 5'h15 : 5'h0a), 10'h0});
    end
    wr(3'h1, 16'hffff); rd(3'h1); chk(r, 32'h5400);
    @(posedge clk) flt <= 1'b1;
    @(posedge clk) flt <= 1'b0;
    rd(3'h1); chk(r[15], 1'b1);
    rd(3'h1); chk(r[15], 1'b0);
    // Fault interrupt: masked, unmasked, then cleared by one
    rd(3'h4); chk(r, 32'h1);
    chk(irq, 1'b0);
    wr(3'h5, 16'h0001); settle(); chk(irq, 1'b1);
    wr(3'h4, 16'h0001); settle(); chk(irq, 1'b0);
    // Only the full idle-error condition counts
    ev(3, 4'hf); ev(2, 4'he); ev(2, 4'hd); ev(2, 4'hb); ev(2, 4'h7);
    rd(3'h1); chk(r[7:0], 8'h03);
    rd(3'h1); chk(r[7:0], 8'h00);
    ev(300, 4'hf); rd(3'h1); chk(r[7:0], 8'hff);
    rd(3'h4); chk(r, 32'h2);
    wr(3'h4, 16'h0002); rd(3'h4); chk(r, 32'h0);
    // Indirect access through every mode, tracking the address
    wr(3'h2, 16'h0005); rd(3'h2); chk(r, 32'h5);
    chk(dev, 5'h05);
    wr(3'h3, 16'h0010); rd(3'h3); chk(r, 32'h10);
    chk(mrd, 1'b0);
    wr(3'h2, 16'h4005); wr(3'h3, 16'haaaa); rd(3'h3); chk(r, 32'haaaa);
    chk(mrd, 1'b1);
    chk(raddr, 16'h0010);
    wr(3'h2, 16'h8005); rd(3'h3); chk(r, 32'haaaa);
    wr(3'h3, 16'h1111); settle(); chk(raddr, 16'h0012);
    wr(3'h2, 16'hc005); rd(3'h3); chk(r, 32'ha512);
    wr(3'h3, 16'h2222); settle(); chk(raddr, 16'h0013);
    wr(3'h2, 16'h0005); wr(3'h3, 16'h0011);
    wr(3'h2, 16'h4005); rd(3'h3); chk(r, 32'h1111);
    // Unmapped word is acknowledged, reads zero, ignores writes
    wr(3'h6, 16'hffff); rd(3'h6); chk(r, 32'h0);
    complete_run();
  end
endmodule : phy_gig_status_mmd_setup_regs_bench
